// >>> rtl/cct_pkg.sv
// package: constants and types for the cycle-timing and page block
package cct_pkg;
    localparam int          CLK_MHZ          = 40;
    localparam int          MAX_CLK_MHZ      = 50;
    localparam logic [7:0]  ADDR_PAGE_SELECT = 8'ha7;
    localparam logic [7:0]  ADDR_PAGE_CTRL   = 8'ha8;
    localparam logic [7:0]  ADDR_LAST_LEN    = 8'ha9;
    localparam logic [7:0]  ADDR_LAST_CYC    = 8'haa;
    localparam logic [7:0]  ADDR_STACK_TOP1  = 8'hab;
    localparam logic [7:0]  PAGE_RESET       = 8'h00;
    localparam int          CTRL_AUTO_BIT    = 0;
    localparam logic [7:0]  CTRL_RESET       = 8'h01;
    localparam int          STACK_DEPTH      = 4;
    localparam int          NUM_SRC          = 8;
    localparam logic [3:0]  MAX_CYCLES       = 4'h8;

    typedef enum logic [1:0] {CCT_OPND_REG, CCT_OPND_DIR, CCT_OPND_IND, CCT_OPND_IMM} cct_opnd_e;
    typedef enum logic [3:0] {
        CCT_OP_ADD, CCT_OP_ADDC, CCT_OP_SUBB, CCT_OP_ANL, CCT_OP_ORL, CCT_OP_XRL,
        CCT_OP_ANL_DIR_A, CCT_OP_ORL_DIR_A, CCT_OP_ANL_DIR_IMM, CCT_OP_ORL_DIR_IMM,
        CCT_OP_INCDEC, CCT_OP_INC_DPTR, CCT_OP_DA, CCT_OP_MUL, CCT_OP_DIV, CCT_OP_NONE
    } cct_op_e;
    typedef enum logic [1:0] {CCT_IDLE, CCT_EXEC} cct_state_e;

    typedef struct packed {
        logic      valid;
        cct_op_e   op;
        cct_opnd_e opnd;
    } cct_instr_s;

    typedef struct packed {
        logic [1:0] len;
        logic [3:0] cycles;
    } cct_timing_s;

    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } cct_bus_s;

    typedef struct packed {
        cct_state_e                   state;
        logic [3:0]                   cnt;
        cct_timing_s                  last;
        logic                         done;
        logic [7:0]                   ctrl;
        logic [STACK_DEPTH-1:0][7:0]  stack;
        logic [2:0]                   sp;
        logic [7:0]                   rdata;
    } cct_state_s;
endpackage : cct_pkg

// >>> rtl/cct_core_timing.sv
// core instruction timing sequencer with register page select and page stack
//
// Summary of operation
// RULE1 - add/addc/subb with working register: one byte, one cycle
// RULE2 - add/addc/subb with direct byte: two bytes, two cycles
// RULE3 - add/addc/subb with indirect ram: one byte, two cycles
// RULE4 - add/addc/subb with immediate: two bytes, two cycles
// RULE5 - and/or/xor into accumulator from register: one byte, one cycle
// RULE6 - and/or/xor into accumulator from direct byte: two bytes, two cycles
// RULE7 - and/or/xor into accumulator from indirect ram: one byte, two cycles
// RULE8 - and/or accumulator into direct byte: two bytes, two cycles
// RULE9 - and/or immediate into direct byte: three bytes, three cycles
// RULE10 - and/or immediate into accumulator: two bytes, two cycles
// RULE11 - no instruction exceeds eight cycles
// RULE12 - fully synchronous design, valid for any clock up to 50 MHz
// RULE13 - page select register answers at 0xa7 on every page
// RULE14 - write sets the page for later accesses; resets to zero
// RULE15 - read returns the page currently in use
// RULE16 - with auto paging on, interrupt entry switches to source page
// RULE17 - interrupt return restores previous page unless stack was altered
// RULE18 - page select is stack top; only interrupts push and pop
// RULE19 - stack depth and source page map are parameters
// RULE20 - inc/dec/inc dptr/da one cycle, mul four, div eight; here inc/dec direct and indirect take two cycles
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/1ps
module cct_core_timing #(
    parameter logic [cct_pkg::NUM_SRC-1:0][7:0] SRC_PAGE = '0  // [RULE19]
) (
    input  wire logic                      mclk,
    input  wire logic                      reset,
    input  wire cct_pkg::cct_instr_s       instr,
    output logic                           instr_ready,
    output logic                           instr_done,
    output logic [1:0]                     instr_len,
    output logic [3:0]                     instr_cycles,
    input  wire logic                      irq_enter,
    input  wire logic [2:0]                irq_src,
    input  wire logic                      irq_return,
    output logic [7:0]                     register_page_select,
    input  wire cct_pkg::cct_bus_s         bus,
    output logic [7:0]                     rdata
);
    cct_pkg::cct_state_s r_ff, nxt_r;
    cct_pkg::cct_timing_s t;

    // length and cycle count of one instruction form
    function automatic cct_pkg::cct_timing_s timing_of(input cct_pkg::cct_instr_s i);
        cct_pkg::cct_timing_s v;
        v.len    = 2'h1;
        v.cycles = 4'h1;
        case (i.op)
            cct_pkg::CCT_OP_ADD, cct_pkg::CCT_OP_ADDC, cct_pkg::CCT_OP_SUBB,
            cct_pkg::CCT_OP_ANL, cct_pkg::CCT_OP_ORL, cct_pkg::CCT_OP_XRL: begin
                case (i.opnd)
                    cct_pkg::CCT_OPND_REG: begin
                        v.len    = 2'h1; // [RULE1] [RULE5]
                        v.cycles = 4'h1;
                    end
                    cct_pkg::CCT_OPND_DIR: begin
                        v.len    = 2'h2; // [RULE2] [RULE6]
                        v.cycles = 4'h2;
                    end
                    cct_pkg::CCT_OPND_IND: begin
                        v.len    = 2'h1; // [RULE3] [RULE7]
                        v.cycles = 4'h2;
                    end
                    default: begin
                        v.len    = 2'h2; // [RULE4] [RULE10]
                        v.cycles = 4'h2;
                    end
                endcase
            end
            cct_pkg::CCT_OP_ANL_DIR_A, cct_pkg::CCT_OP_ORL_DIR_A: begin
                v.len    = 2'h2; // [RULE8]
                v.cycles = 4'h2;
            end
            cct_pkg::CCT_OP_ANL_DIR_IMM, cct_pkg::CCT_OP_ORL_DIR_IMM: begin
                v.len    = 2'h3; // [RULE9]
                v.cycles = 4'h3;
            end
            cct_pkg::CCT_OP_INCDEC: begin
                // inc/dec of memory forms follow the operand table like add
                case (i.opnd)
                    cct_pkg::CCT_OPND_DIR: begin
                        v.len    = 2'h2;
                        v.cycles = 4'h2;
                    end
                    cct_pkg::CCT_OPND_IND: begin
                        v.len    = 2'h1;
                        v.cycles = 4'h2;
                    end
                    default: begin
                        v.len    = 2'h1; // [RULE20]
                        v.cycles = 4'h1;
                    end
                endcase
            end
            cct_pkg::CCT_OP_INC_DPTR, cct_pkg::CCT_OP_DA: begin
                v.len    = 2'h1; // [RULE20]
                v.cycles = 4'h1;
            end
            cct_pkg::CCT_OP_MUL: begin
                v.len    = 2'h1; // [RULE20]
                v.cycles = 4'h4;
            end
            cct_pkg::CCT_OP_DIV: begin
                v.len    = 2'h1; // [RULE20] [RULE11]
                v.cycles = cct_pkg::MAX_CYCLES;
            end
            default: begin
                v.len    = 2'h1;
                v.cycles = 4'h1;
            end
        endcase
        return v;
    endfunction : timing_of

    // page that an interrupt source owns
    function automatic logic [7:0] src_page(input logic [2:0] s);
        return SRC_PAGE[s]; // [RULE19]
    endfunction : src_page

    // one register of the port is written in this cycle
    function automatic logic wr_hit(input cct_pkg::cct_bus_s b, input logic [7:0] a);
        return b.wr && b.addr == a;
    endfunction : wr_hit

    assign t = timing_of(instr);

    always_comb begin
        nxt_r      = r_ff;
        nxt_r.done = 1'b0;
        // sequencer: accept when idle, hold for the instruction's cycles
        case (r_ff.state)
            cct_pkg::CCT_IDLE: begin
                if (instr.valid) begin
                    nxt_r.last = t;
                    if (t.cycles == 4'h1) begin
                        nxt_r.done = 1'b1;
                    end else begin
                        nxt_r.cnt   = t.cycles - 4'h1;
                        nxt_r.state = cct_pkg::CCT_EXEC;
                    end
                end
            end
            cct_pkg::CCT_EXEC: begin
                nxt_r.cnt = r_ff.cnt - 4'h1;
                if (r_ff.cnt == 4'h1) begin
                    nxt_r.done  = 1'b1; // [RULE11]
                    nxt_r.state = cct_pkg::CCT_IDLE;
                end
            end
            default: nxt_r.state = cct_pkg::CCT_IDLE;
        endcase

        // a page select write alters only the stack top, never pushes or pops
        if (wr_hit(bus, cct_pkg::ADDR_PAGE_SELECT)) begin
            nxt_r.stack[0] = bus.wdata; // [RULE13] [RULE14] [RULE18]
        end
        // the entry below the top is writable so a handler can alter the return page
        if (wr_hit(bus, cct_pkg::ADDR_STACK_TOP1)) begin
            nxt_r.stack[1] = bus.wdata; // [RULE17]
        end
        if (wr_hit(bus, cct_pkg::ADDR_PAGE_CTRL)) begin
            nxt_r.ctrl = bus.wdata;
        end

        // interrupt entry pushes and switches; return pops. entry wins over return when auto paging is on.
        // the enable is the registered one, so a control write acts from the next cycle
        if (irq_enter && r_ff.ctrl[cct_pkg::CTRL_AUTO_BIT]) begin
            for (int k = cct_pkg::STACK_DEPTH - 1; k > 0; k--) begin
                nxt_r.stack[k] = nxt_r.stack[k-1]; // [RULE18]
            end
            nxt_r.stack[0] = src_page(irq_src); // [RULE16]
            if (r_ff.sp != 3'(cct_pkg::STACK_DEPTH - 1)) begin
                nxt_r.sp = r_ff.sp + 3'h1;
            end
        end else if (irq_return && r_ff.sp != 3'h0) begin
            for (int k = 0; k < cct_pkg::STACK_DEPTH - 1; k++) begin
                nxt_r.stack[k] = nxt_r.stack[k+1]; // [RULE17] [RULE18]
            end
            nxt_r.stack[cct_pkg::STACK_DEPTH-1] = cct_pkg::PAGE_RESET;
            nxt_r.sp = r_ff.sp - 3'h1;
        end

        nxt_r.rdata = 8'h00;
        if (bus.rd) begin
            case (bus.addr)
                cct_pkg::ADDR_PAGE_SELECT: nxt_r.rdata = r_ff.stack[0]; // [RULE15]
                cct_pkg::ADDR_PAGE_CTRL:   nxt_r.rdata = r_ff.ctrl;
                cct_pkg::ADDR_LAST_LEN:    nxt_r.rdata = {6'h00, r_ff.last.len};
                cct_pkg::ADDR_LAST_CYC:    nxt_r.rdata = {4'h0, r_ff.last.cycles};
                cct_pkg::ADDR_STACK_TOP1:  nxt_r.rdata = r_ff.stack[1];
                default:                   nxt_r.rdata = 8'h00;
            endcase
        end
    end

    // single synchronous clock domain; no path depends on clock rate [RULE12]
    always_ff @(posedge mclk) begin
        if (reset) begin
            r_ff.state <= cct_pkg::CCT_IDLE;
            r_ff.cnt   <= 4'h0;
            r_ff.last  <= '0;
            r_ff.done  <= 1'b0;
            r_ff.ctrl  <= cct_pkg::CTRL_RESET;
            r_ff.stack <= '0; // [RULE14]
            r_ff.sp    <= 3'h0;
            r_ff.rdata <= 8'h00;
        end else begin
            r_ff <= nxt_r;
        end
    end

    assign instr_ready          = (r_ff.state == cct_pkg::CCT_IDLE);
    assign instr_done           = r_ff.done;
    assign instr_len            = r_ff.last.len;
    assign instr_cycles         = r_ff.last.cycles;
    assign register_page_select = r_ff.stack[0];
    assign rdata                = r_ff.rdata;

    // cycle counter from accept to done, for checks
    logic [3:0] chk_cnt_ff;
    always_ff @(posedge mclk) begin
        if (reset || instr_done) begin
            chk_cnt_ff <= 4'h0;
        end else if (!instr_ready || instr.valid) begin
            chk_cnt_ff <= chk_cnt_ff + 4'h1;
        end
    end

    // request qualifiers shared by the timing checks
    logic chk_take;
    logic chk_arith;
    logic chk_logic;
    assign chk_take  = instr_ready && instr.valid;
    assign chk_arith = instr.op inside {cct_pkg::CCT_OP_ADD, cct_pkg::CCT_OP_ADDC, cct_pkg::CCT_OP_SUBB};
    assign chk_logic = instr.op inside {cct_pkg::CCT_OP_ANL, cct_pkg::CCT_OP_ORL, cct_pkg::CCT_OP_XRL};

    default clocking cb @(posedge mclk); endclocking
    default disable iff (reset);

    reg_one_cycle_a: assert property (instr_ready && instr.valid && instr.op == cct_pkg::CCT_OP_ADD && // [RULE1]
        instr.opnd == cct_pkg::CCT_OPND_REG |=> instr_done && instr_cycles == 4'h1 && instr_len == 2'h1)
        else $error("register add not one cycle");
    dir_two_cycle_a: assert property (instr_ready && instr.valid && instr.op == cct_pkg::CCT_OP_ADDC && // [RULE2]
        instr.opnd == cct_pkg::CCT_OPND_DIR |=> !instr_done ##1 instr_done && instr_len == 2'h2)
        else $error("direct addc not two cycles");
    ind_two_cycle_a: assert property (instr_ready && instr.valid && instr.op == cct_pkg::CCT_OP_XRL && // [RULE7]
        instr.opnd == cct_pkg::CCT_OPND_IND |=> !instr_done ##1 instr_done && instr_len == 2'h1)
        else $error("indirect xrl not two cycles");
    dir_imm_three_a: assert property (instr_ready && instr.valid && instr.op == cct_pkg::CCT_OP_ORL_DIR_IMM // [RULE9]
        |=> (!instr_done)[*2] ##1 instr_done && instr_len == 2'h3)
        else $error("orl direct immediate not three cycles");
    max_eight_a: assert property (chk_cnt_ff <= cct_pkg::MAX_CYCLES) // [RULE11]
        else $error("instruction over eight cycles");
    page_write_a: assert property (bus.wr && bus.addr == cct_pkg::ADDR_PAGE_SELECT && !irq_enter && !irq_return // [RULE14]
        |=> register_page_select == $past(bus.wdata))
        else $error("page write not taken");
    page_read_a: assert property (bus.rd && bus.addr == cct_pkg::ADDR_PAGE_SELECT // [RULE15]
        |=> rdata == $past(register_page_select))
        else $error("page read mismatch");
    irq_switch_a: assert property (irq_enter && r_ff.ctrl[cct_pkg::CTRL_AUTO_BIT] && !bus.wr // [RULE16]
        |=> register_page_select == src_page($past(irq_src)))
        else $error("page not switched on interrupt");
    irq_restore_a: assert property (irq_enter && r_ff.ctrl[cct_pkg::CTRL_AUTO_BIT] && !bus.wr // [RULE17]
        ##1 !irq_enter && !irq_return && !bus.wr
        ##1 irq_return && !irq_enter && !bus.wr
        |=> register_page_select == $past(register_page_select, 3))
        else $error("page not restored on return");
    no_pop_read_a: assert property (!irq_enter && !irq_return && !bus.wr |=> $stable(r_ff.sp)) // [RULE18]
        else $error("stack moved without interrupt");

    // length and cycle count of each form, except memory inc/dec and anl/orl indirect
    arith_reg_a: assert property (chk_take && chk_arith && instr.opnd == cct_pkg::CCT_OPND_REG // [RULE1]
        |=> instr_done && instr_len == 2'h1)
        else $error("arithmetic register form not one cycle");
    arith_dir_a: assert property (chk_take && chk_arith && instr.opnd == cct_pkg::CCT_OPND_DIR // [RULE2]
        |=> !instr_done ##1 instr_done && instr_len == 2'h2)
        else $error("arithmetic direct form not two cycles");
    arith_ind_a: assert property (chk_take && chk_arith && instr.opnd == cct_pkg::CCT_OPND_IND // [RULE3]
        |=> !instr_done ##1 instr_done && instr_len == 2'h1)
        else $error("arithmetic indirect form not two cycles");
    arith_imm_a: assert property (chk_take && chk_arith && instr.opnd == cct_pkg::CCT_OPND_IMM // [RULE4]
        |=> !instr_done ##1 instr_done && instr_len == 2'h2)
        else $error("arithmetic immediate form not two cycles");
    logic_reg_a: assert property (chk_take && chk_logic && instr.opnd == cct_pkg::CCT_OPND_REG // [RULE5]
        |=> instr_done && instr_len == 2'h1)
        else $error("logic register form not one cycle");
    logic_dir_a: assert property (chk_take && chk_logic && instr.opnd == cct_pkg::CCT_OPND_DIR // [RULE6]
        |=> !instr_done ##1 instr_done && instr_len == 2'h2)
        else $error("logic direct form not two cycles");
    logic_imm_a: assert property (chk_take && chk_logic && instr.opnd == cct_pkg::CCT_OPND_IMM // [RULE10]
        |=> !instr_done ##1 instr_done && instr_len == 2'h2)
        else $error("logic immediate form not two cycles");
    dir_acc_a: assert property (chk_take && instr.op inside {cct_pkg::CCT_OP_ANL_DIR_A, cct_pkg::CCT_OP_ORL_DIR_A} // [RULE8]
        |=> !instr_done ##1 instr_done && instr_len == 2'h2)
        else $error("accumulator into direct not two cycles");
    and_dir_imm_a: assert property (chk_take && instr.op == cct_pkg::CCT_OP_ANL_DIR_IMM // [RULE9]
        |=> (!instr_done)[*2] ##1 instr_done && instr_len == 2'h3)
        else $error("and direct immediate not three cycles");
    mul_four_a: assert property (chk_take && instr.op == cct_pkg::CCT_OP_MUL // [RULE20]
        |=> (!instr_done)[*3] ##1 instr_done && instr_cycles == 4'h4)
        else $error("multiply not four cycles");
    div_eight_a: assert property (chk_take && instr.op == cct_pkg::CCT_OP_DIV // [RULE20] [RULE11]
        |=> (!instr_done)[*7] ##1 instr_done && instr_cycles == 4'h8)
        else $error("divide not eight cycles");
    incdec_one_a: assert property (chk_take && instr.op == cct_pkg::CCT_OP_INCDEC // [RULE20]
        && instr.opnd == cct_pkg::CCT_OPND_REG |=> instr_done && instr_len == 2'h1)
        else $error("register increment not one cycle");
    dptr_da_a: assert property (chk_take && instr.op inside {cct_pkg::CCT_OP_INC_DPTR, cct_pkg::CCT_OP_DA} // [RULE20]
        |=> instr_done && instr_len == 2'h1)
        else $error("pointer increment or adjust not one cycle");

    // sequencer: a busy request is dropped, and busy never outlasts the longest form
    busy_drop_a: assert property (!instr_ready && instr.valid // [RULE11]
        |=> $stable(instr_len) && $stable(instr_cycles))
        else $error("request taken while busy");
    done_ready_a: assert property (instr_done |-> instr_ready) // [RULE11]
        else $error("done while still busy");
    busy_bound_a: assert property (!instr_ready |-> ##[1:7] instr_ready) // [RULE11]
        else $error("sequencer busy too long");

    // register port and page stack
    page_hold_a: assert property (!bus.wr && !irq_enter && !irq_return // [RULE14]
        |=> $stable(register_page_select))
        else $error("page changed with no cause");
    rdata_zero_a: assert property (!bus.rd |=> rdata == 8'h00) // [RULE15]
        else $error("read data without a read");
    ctrl_write_a: assert property (bus.wr && bus.addr == cct_pkg::ADDR_PAGE_CTRL
        |=> r_ff.ctrl == $past(bus.wdata))
        else $error("control write not taken");
    len_read_a: assert property (bus.rd && bus.addr == cct_pkg::ADDR_LAST_LEN
        |=> rdata == {6'h00, $past(instr_len)})
        else $error("length read mismatch");
    auto_off_a: assert property (irq_enter && !r_ff.ctrl[cct_pkg::CTRL_AUTO_BIT] // [RULE16]
        && !irq_return && !bus.wr
        |=> $stable(register_page_select))
        else $error("page switched with auto paging off");
    empty_return_a: assert property (irq_return && r_ff.sp == 3'h0 // [RULE17]
        && !irq_enter && !bus.wr
        |=> $stable(register_page_select))
        else $error("return with empty stack moved page");
    alter_restore_a: assert property (bus.wr && bus.addr == cct_pkg::ADDR_STACK_TOP1 // [RULE17]
        && !irq_enter && !irq_return
        ##1 !irq_enter && !irq_return && !bus.wr
        ##1 irq_return && !irq_enter && !bus.wr && r_ff.sp != 3'h0
        |=> register_page_select == $past(bus.wdata, 3))
        else $error("altered return page not restored");
    push_depth_a: assert property (irq_enter && r_ff.ctrl[cct_pkg::CTRL_AUTO_BIT] // [RULE18]
        && r_ff.sp != 3'(cct_pkg::STACK_DEPTH - 1)
        |=> r_ff.sp == $past(r_ff.sp) + 3'h1)
        else $error("entry did not push");
    pop_depth_a: assert property (irq_return && !irq_enter && r_ff.sp != 3'h0 // [RULE18]
        |=> r_ff.sp == $past(r_ff.sp) - 3'h1)
        else $error("return did not pop");
    sp_bound_a: assert property (r_ff.sp <= 3'(cct_pkg::STACK_DEPTH - 1)) // [RULE19]
        else $error("stack depth out of range");
    reset_page_a: assert property ($fell(reset) // [RULE14]
        |-> register_page_select == cct_pkg::PAGE_RESET && instr_ready
            && !instr_done && rdata == 8'h00)
        else $error("state after reset wrong");

    mul_cov: cover property (instr.valid && instr_ready && instr.op == cct_pkg::CCT_OP_MUL ##4 instr_done);
    div_cov: cover property (instr.valid && instr_ready && instr.op == cct_pkg::CCT_OP_DIV ##8 instr_done);
    nest_cov: cover property (irq_enter ##1 irq_enter ##1 irq_return ##1 irq_return);
    alter_cov: cover property (bus.wr && bus.addr == cct_pkg::ADDR_STACK_TOP1 ##1 irq_return);
endmodule : cct_core_timing

// >>> dv/cct_core_timing_tb.sv
// testbench for the instruction timing sequencer and the register page stack
`timescale 1ns/1ps
module cct_core_timing_tb;
    typedef struct packed {
        cct_pkg::cct_op_e   op;
        cct_pkg::cct_opnd_e opnd;
        logic [1:0]         len;
        logic [3:0]         cyc;
    } cct_row_s;
    localparam cct_row_s ROWS [18] = '{
        '{cct_pkg::CCT_OP_ADD, cct_pkg::CCT_OPND_REG, 2'h1, 4'h1},
        '{cct_pkg::CCT_OP_ADDC, cct_pkg::CCT_OPND_DIR, 2'h2, 4'h2},
        '{cct_pkg::CCT_OP_SUBB, cct_pkg::CCT_OPND_IND, 2'h1, 4'h2},
        '{cct_pkg::CCT_OP_ADDC, cct_pkg::CCT_OPND_IMM, 2'h2, 4'h2},
        '{cct_pkg::CCT_OP_XRL, cct_pkg::CCT_OPND_REG, 2'h1, 4'h1},
        '{cct_pkg::CCT_OP_ANL, cct_pkg::CCT_OPND_DIR, 2'h2, 4'h2},
        '{cct_pkg::CCT_OP_ORL, cct_pkg::CCT_OPND_IND, 2'h1, 4'h2},
        '{cct_pkg::CCT_OP_ORL, cct_pkg::CCT_OPND_IMM, 2'h2, 4'h2},
        '{cct_pkg::CCT_OP_ANL_DIR_A, cct_pkg::CCT_OPND_DIR, 2'h2, 4'h2},
        '{cct_pkg::CCT_OP_ORL_DIR_A, cct_pkg::CCT_OPND_DIR, 2'h2, 4'h2},
        '{cct_pkg::CCT_OP_ANL_DIR_IMM, cct_pkg::CCT_OPND_DIR, 2'h3, 4'h3},
        '{cct_pkg::CCT_OP_ORL_DIR_IMM, cct_pkg::CCT_OPND_DIR, 2'h3, 4'h3},
        '{cct_pkg::CCT_OP_INCDEC, cct_pkg::CCT_OPND_REG, 2'h1, 4'h1},
        '{cct_pkg::CCT_OP_DA, cct_pkg::CCT_OPND_REG, 2'h1, 4'h1},
        '{cct_pkg::CCT_OP_INCDEC, cct_pkg::CCT_OPND_IND, 2'h1, 4'h2},
        '{cct_pkg::CCT_OP_INC_DPTR, cct_pkg::CCT_OPND_REG, 2'h1, 4'h1},
        '{cct_pkg::CCT_OP_MUL, cct_pkg::CCT_OPND_REG, 2'h1, 4'h4},
        '{cct_pkg::CCT_OP_DIV, cct_pkg::CCT_OPND_REG, 2'h1, 4'h8}
    };
    logic                mclk;
    logic                reset;
    cct_pkg::cct_instr_s instr;
    logic                instr_ready;
    logic                instr_done;
    logic [1:0]          instr_len;
    logic [3:0]          instr_cycles;
    logic                irq_enter;
    logic [2:0]          irq_src;
    logic                irq_return;
    logic [7:0]          register_page_select;
    cct_pkg::cct_bus_s   bus;
    logic [7:0]          rdata;
    int                  num_errors;
    int                  cmp_count;
    // distinct page per source so a wrong index shows up
    cct_core_timing #(.SRC_PAGE(64'h1716151413121110)) cct_core_timing_i (
        .mclk(mclk), .reset(reset), .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done),
        .instr_len(instr_len), .instr_cycles(instr_cycles), .irq_enter(irq_enter), .irq_src(irq_src),
        .irq_return(irq_return), .register_page_select(register_page_select), .bus(bus), .rdata(rdata));
    initial begin
        mclk = 1'b0;
        forever #12.5 mclk = ~mclk;
    end
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : close_out
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        cmp_count++;
        if (got !== exp) begin
            $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
            num_errors++;
        end
    endtask : chk
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge mclk);
        bus <= '0;
    endtask : wr
    // read data stand only in the cycle after the strobe
    task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
        @(posedge mclk);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1 chk(what, exp, rdata);
    endtask : rd
    task automatic irq(input logic e, input logic r, input logic [2:0] s, input logic [7:0] exp);
        @(posedge mclk);
        irq_enter <= e;
        irq_return <= r;
        irq_src <= s;
        @(posedge mclk);
        irq_enter <= 1'b0;
        irq_return <= 1'b0;
        #1 chk("page_port", exp, register_page_select);
    endtask : irq
    task automatic run(input cct_row_s r);
        int n;
        @(posedge mclk);
        instr <= '{valid: 1'b1, op: r.op, opnd: r.opnd};
        @(posedge mclk);
        instr.valid <= 1'b0;
        // a one-cycle form shows done right after the taking edge
        n = 1;
        #1;
        while (instr_done !== 1'b1 && n < 12) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n >= 12) begin
            num_errors++;
            close_out();
        end else begin
            chk("cycles_seen", {4'h0, r.cyc}, n[7:0]);
            chk("len_port", {6'h0, r.len}, {6'h0, instr_len});
            chk("cycles_port", {4'h0, r.cyc}, {4'h0, instr_cycles});
        end
    endtask : run
    initial begin
        num_errors = 0;
        cmp_count = 0;
        instr = '0;
        bus = '0;
        irq_enter = 1'b0;
        irq_return = 1'b0;
        irq_src = 3'h0;
        reset = 1'b1;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        rd(cct_pkg::ADDR_PAGE_SELECT, 8'h00, "page_reset");
        rd(cct_pkg::ADDR_PAGE_CTRL, 8'h01, "ctrl_reset");
        wr(8'h00, 8'h5a);
        rd(8'h00, 8'h00, "unmapped");
        @(posedge mclk);
        #1 chk("rdata_idle", 8'h00, rdata);
        foreach (ROWS[i]) run(ROWS[i]);
        rd(cct_pkg::ADDR_LAST_LEN, 8'h01, "last_len");
        wr(cct_pkg::ADDR_LAST_CYC, 8'h0f);
        rd(cct_pkg::ADDR_LAST_CYC, 8'h08, "last_cyc_ro");
        wr(cct_pkg::ADDR_PAGE_SELECT, 8'h35);
        rd(cct_pkg::ADDR_PAGE_SELECT, 8'h35, "page_rw");
        irq(1'b1, 1'b0, 3'h2, 8'h12);
        rd(cct_pkg::ADDR_STACK_TOP1, 8'h35, "stack_below");
        irq(1'b1, 1'b0, 3'h5, 8'h15);
        irq(1'b0, 1'b1, 3'h0, 8'h12);
        // a software write replaces the top, it must not push
        wr(cct_pkg::ADDR_PAGE_SELECT, 8'h44);
        rd(cct_pkg::ADDR_PAGE_SELECT, 8'h44, "page_in_isr");
        irq(1'b0, 1'b1, 3'h0, 8'h35);
        irq(1'b0, 1'b1, 3'h0, 8'h35);
        irq(1'b1, 1'b0, 3'h1, 8'h11);
        wr(cct_pkg::ADDR_STACK_TOP1, 8'h66);
        irq(1'b0, 1'b1, 3'h0, 8'h66);
        wr(cct_pkg::ADDR_PAGE_CTRL, 8'h00);
        irq(1'b1, 1'b0, 3'h3, 8'h66);
        wr(cct_pkg::ADDR_PAGE_CTRL, 8'h01);
        // a request while busy is dropped, not queued
        @(posedge mclk);
        instr <= '{valid: 1'b1, op: cct_pkg::CCT_OP_DIV, opnd: cct_pkg::CCT_OPND_REG};
        @(posedge mclk);
        instr <= '{valid: 1'b1, op: cct_pkg::CCT_OP_MUL, opnd: cct_pkg::CCT_OPND_REG};
        @(posedge mclk);
        instr.valid <= 1'b0;
        repeat (6) @(posedge mclk);
        #1 chk("div_done", 8'h01, {7'h0, instr_done});
        @(posedge mclk);
        #1 chk("ready_after", 8'h01, {7'h0, instr_ready});
        chk("cycles_kept", 8'h08, {4'h0, instr_cycles});
        // reset in mid-run empties the stack and brings the page back to zero
        irq(1'b1, 1'b0, 3'h4, 8'h14);
        @(posedge mclk);
        reset <= 1'b1;
        repeat (2) @(posedge mclk);
        reset <= 1'b0;
        #1 chk("page_after_reset", 8'h00, register_page_select);
        rd(cct_pkg::ADDR_PAGE_CTRL, 8'h01, "ctrl_after_reset");
        irq(1'b0, 1'b1, 3'h0, 8'h00);
        close_out();
    end
endmodule : cct_core_timing_tb
